// *** rtl/alm_consts.svh ***
// Constants of the ADC limit monitor
`ifndef ALM_CONSTS_SVH
`define ALM_CONSTS_SVH
`define ALM_CODE_MAX   12'hfff
`define ALM_CODE_MIN   12'h000
`define ALM_HYS_VOLT   12'h008
`define ALM_HYS_TEMP   12'h020
`define ALM_HYS_MINMAX 12'hfff
`define ALM_OFS_CFG    8'h03
`define ALM_OFS_STA    8'h04
`define ALM_OFS_STB    8'h05
`define ALM_OFS_STC    8'h06
`define ALM_LIM_REGION 2'h1
`define ALM_CFG_RST    2'h3
`define ALM_CFG_PIN    0
`define ALM_CFG_FLAG   1
`define ALM_STB_OVR    4
`define ALM_STC_DIODE  7
`define ALM_LIM_FLAG   11
`endif

// *** rtl/alm_pkg.sv ***
// Types of the ADC limit monitor
package alm_pkg;
  typedef logic [11:0] alm_code_t;
  typedef enum logic [1:0] {
    alm_sel_low  = 2'b00,
    alm_sel_high = 2'b01,
    alm_sel_hys  = 2'b10,
    alm_sel_none = 2'b11
  } alm_sel_e;
endpackage : alm_pkg

// *** rtl/alm_chan_if.sv ***
// Carrier between the monitor core and one channel checker
`timescale 1ns/100ps
interface alm_chan_if;
  import alm_pkg::*;
  logic      wr_low;
  logic      wr_high;
  logic      wr_hys;
  alm_code_t wdata;
  logic      res_vld;
  alm_code_t code;
  logic      clr_high;
  logic      clr_low;
  alm_code_t upper;
  alm_code_t lower;
  alm_code_t hys;
  logic      viol_high;
  logic      viol_low;
  modport ctl (output wr_low, wr_high, wr_hys, wdata, res_vld, code, clr_high, clr_low,
               input upper, lower, hys, viol_high, viol_low);
  modport chan (input wr_low, wr_high, wr_hys, wdata, res_vld, code, clr_high, clr_low,
                output upper, lower, hys, viol_high, viol_low);
endinterface : alm_chan_if

// *** rtl/alm_chan.sv ***
// One channel: limit, hysteresis and min/max registers with alert state
`timescale 1ns/100ps
`include "alm_consts.svh"
module alm_chan #(
  parameter bit IS_TEMP = 1'b0
) (
  input  wire logic clock, // System clock
  input  wire logic rst_b, // Async reset, active low
  alm_chan_if.chan  bus    // Core side
);
  import alm_pkg::*;

  alm_code_t upper_ff;
  alm_code_t lower_ff;
  alm_code_t hys_ff;
  logic      high_ff;
  logic      low_ff;

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // All compares unsigned; sums widened so a large N never wraps
  wire        minmax   = (hys_ff == `ALM_HYS_MINMAX);
  wire        chk      = bus.res_vld && !minmax;
  wire        above    = bus.code > upper_ff;
  wire        below    = bus.code < lower_ff;
  wire [12:0] code_hys = {1'b0, bus.code} + {1'b0, hys_ff};
  wire [12:0] low_hys  = {1'b0, lower_ff} + {1'b0, hys_ff};
  wire        rel_high = code_hys <= {1'b0, upper_ff};
  wire        rel_low  = {1'b0, bus.code} >= low_hys;
  wire        mm_up    = bus.res_vld && minmax && above;
  wire        mm_dn    = bus.res_vld && minmax && below;

  // Set wins over auto release and host clear
  wire nxt_high = (chk && above) ? 1'b1 :
                  ((chk && rel_high) || bus.clr_high) ? 1'b0 : high_ff;
  wire nxt_low  = (chk && below) ? 1'b1 :
                  ((chk && rel_low) || bus.clr_low) ? 1'b0 : low_ff;
  // Host write takes precedence over the min/max recorder
  wire alm_code_t nxt_upper = bus.wr_high ? bus.wdata : mm_up ? bus.code : upper_ff;
  wire alm_code_t nxt_lower = bus.wr_low  ? bus.wdata : mm_dn ? bus.code : lower_ff;
  wire alm_code_t nxt_hys   = bus.wr_hys  ? bus.wdata : hys_ff;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Limits open fully and hysteresis per channel type after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upper_ff <= `ALM_CODE_MAX;
      lower_ff <= `ALM_CODE_MIN;
      hys_ff   <= IS_TEMP ? `ALM_HYS_TEMP : `ALM_HYS_VOLT;
      high_ff  <= 1'b0;
      low_ff   <= 1'b0;
    end else begin
      upper_ff <= nxt_upper;
      lower_ff <= nxt_lower;
      hys_ff   <= nxt_hys;
      high_ff  <= nxt_high;
      low_ff   <= nxt_low;
    end
  end

  // Outputs to the core
  assign bus.upper     = upper_ff;
  assign bus.lower     = lower_ff;
  assign bus.hys       = hys_ff;
  assign bus.viol_high = high_ff;
  assign bus.viol_low  = low_ff;
endmodule : alm_chan

// *** rtl/adc_limit_monitor.sv ***
// Limit monitor core: channel array, status registers and alert outputs
`timescale 1ns/100ps
`include "alm_consts.svh"
module adc_limit_monitor #(
  parameter int N_CH    = 9, // Monitored channels
  parameter int TEMP_LO = 6  // First temperature channel
) (
  input  wire logic             clock,          // 20 MHz system clock
  input  wire logic             rst_b,          // Async reset, active low
  input  wire logic             res_valid,      // Conversion result strobe
  input  wire logic [3:0]       res_chan,       // Channel of the result
  input  wire alm_pkg::alm_code_t res_code,     // Conversion result code
  input  wire logic [1:0]       ovr_pin,        // Current overrange comparators
  input  wire logic [1:0]       diode_open_pin, // Remote diode open detectors
  input  wire logic             reg_wr,         // Register write strobe
  input  wire logic             reg_rd,         // Register read strobe
  input  wire logic [7:0]       reg_addr,       // Register address
  input  wire alm_pkg::alm_code_t reg_wdata,    // Register write data
  output alm_pkg::alm_code_t    reg_rdata,      // Register read data
  output logic                  alert_pin,      // Limit event output, high active
  output logic                  alert_flag      // Violation indicator bit
);
  import alm_pkg::*;

  localparam logic [3:0] N_CH_W = 4'(N_CH);
  localparam logic [3:0] DIO0   = 4'(TEMP_LO);
  localparam logic [3:0] DIO1   = 4'(TEMP_LO + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ovr_s1_ff;
  logic [1:0] ovr_s2_ff;
  logic [1:0] dio_s1_ff;
  logic [1:0] dio_s2_ff;

  // Two stages before any logic looks at the analog comparators
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ovr_s1_ff <= 2'h0;
      ovr_s2_ff <= 2'h0;
      dio_s1_ff <= 2'h0;
      dio_s2_ff <= 2'h0;
    end else begin
      ovr_s1_ff <= ovr_pin;
      ovr_s2_ff <= ovr_s1_ff;
      dio_s1_ff <= diode_open_pin;
      dio_s2_ff <= dio_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [1:0] cfg_ff;
  logic [1:0] ovr_sta_ff;
  logic       dio_sta_ff;

  // Limit region: channel in [5:2], register select in [1:0]
  wire        lim_hit = reg_addr[7:6] == `ALM_LIM_REGION;
  wire [3:0]  lim_ch  = reg_addr[5:2];
  wire        ch_ok   = lim_ch < N_CH_W;
  alm_sel_e   lim_sel;
  assign lim_sel = alm_sel_e'(reg_addr[1:0]);

  // Write strobes of the flat registers
  wire        cfg_wr  = reg_wr && (reg_addr == `ALM_OFS_CFG);
  wire [2:0]  sta_wr;
  assign sta_wr[0] = reg_wr && (reg_addr == `ALM_OFS_STA);
  assign sta_wr[1] = reg_wr && (reg_addr == `ALM_OFS_STB);
  assign sta_wr[2] = reg_wr && (reg_addr == `ALM_OFS_STC);

  // ----------------------------------------------------------------
  // Channel array
  // ----------------------------------------------------------------
  alm_code_t up_a [N_CH];
  alm_code_t lo_a [N_CH];
  alm_code_t hy_a [N_CH];
  wire [2:0][7:0] sta_w;

  // Status layout: group of 4, 2, 3 channels; low bit lo, next bit hi
  for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
    localparam int GRP = (ch < 4) ? 0 : (ch < TEMP_LO) ? 1 : 2;
    localparam int POS = (ch < 4) ? 2 * ch : (ch < TEMP_LO) ? 2 * (ch - 4)
                                           : 2 * (ch - TEMP_LO);
    localparam logic [3:0] CH_W = 4'(ch);
    wire wr_this = reg_wr && lim_hit && (lim_ch == CH_W);

    alm_chan_if u_if ();

    // Host side of the channel
    assign u_if.wr_low   = wr_this && (lim_sel == alm_sel_low);
    assign u_if.wr_high  = wr_this && (lim_sel == alm_sel_high);
    assign u_if.wr_hys   = wr_this && (lim_sel == alm_sel_hys);
    assign u_if.wdata    = reg_wdata;
    assign u_if.clr_low  = sta_wr[GRP] && reg_wdata[POS];
    assign u_if.clr_high = sta_wr[GRP] && reg_wdata[POS + 1];

    // Result stream steered to its channel
    assign u_if.res_vld  = res_valid && (res_chan == CH_W);
    assign u_if.code     = res_code;

    // Readback and status collection
    assign up_a[ch]           = u_if.upper;
    assign lo_a[ch]           = u_if.lower;
    assign hy_a[ch]           = u_if.hys;
    assign sta_w[GRP][POS]    = u_if.viol_low;
    assign sta_w[GRP][POS+1]  = u_if.viol_high;

    alm_chan #(
      .IS_TEMP (ch >= TEMP_LO)
    ) u_chan (
      .clock (clock),
      .rst_b (rst_b),
      .bus   (u_if.chan)
    );
  end

  // Bits above the channel pairs
  assign sta_w[1][7:4] = {2'h0, ovr_sta_ff};
  assign sta_w[2][7:6] = {dio_sta_ff, 1'b0};

  // ----------------------------------------------------------------
  // Sticky alerts
  // ----------------------------------------------------------------
  // Host clear by writing one; a live input sets again at once
  wire [1:0] ovr_clr = sta_wr[1] ? reg_wdata[`ALM_STB_OVR +: 2] : 2'h0;
  wire       dio_clr = sta_wr[2] && reg_wdata[`ALM_STC_DIODE];
  wire [1:0] nxt_ovr_sta = ovr_s2_ff | (ovr_sta_ff & ~ovr_clr);
  wire       nxt_dio_sta = (|dio_s2_ff) | (dio_sta_ff & ~dio_clr);
  wire [1:0] nxt_cfg     = cfg_wr ? reg_wdata[1:0] : cfg_ff;

  // Configuration and latched fault state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff     <= `ALM_CFG_RST;
      ovr_sta_ff <= 2'h0;
      dio_sta_ff <= 1'b0;
    end else begin
      cfg_ff     <= nxt_cfg;
      ovr_sta_ff <= nxt_ovr_sta;
      dio_sta_ff <= nxt_dio_sta;
    end
  end

  // ----------------------------------------------------------------
  // Alert outputs
  // ----------------------------------------------------------------
  // Limit bits follow the latest results, so a recovered channel drops
  wire any_lim = (|sta_w[0]) || (|sta_w[1][3:0]) || (|sta_w[2][5:0]);
  wire any_all = any_lim || (|ovr_sta_ff) || dio_sta_ff;
  wire nxt_pin  = cfg_ff[`ALM_CFG_PIN] && any_all;
  wire nxt_flag = cfg_ff[`ALM_CFG_FLAG] && any_lim;

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Remote diode channels show the inverted open flag (one while the diode is fine) in bit 11 of their limits
  wire        is_dio  = (lim_ch == DIO0) || (lim_ch == DIO1);
  wire        dio_ok  = (lim_ch == DIO0) ? ~dio_s2_ff[0] : ~dio_s2_ff[1];
  wire alm_code_t up_rd = ch_ok ? up_a[lim_ch] : `ALM_CODE_MIN;
  wire alm_code_t lo_rd = ch_ok ? lo_a[lim_ch] : `ALM_CODE_MIN;
  wire alm_code_t hy_rd = ch_ok ? hy_a[lim_ch] : `ALM_CODE_MIN;
  wire alm_code_t up_fl = {is_dio ? dio_ok : up_rd[`ALM_LIM_FLAG],
                           up_rd[`ALM_LIM_FLAG-1:0]};
  wire alm_code_t lo_fl = {is_dio ? dio_ok : lo_rd[`ALM_LIM_FLAG],
                           lo_rd[`ALM_LIM_FLAG-1:0]};

  // Limit region word by register select
  wire alm_code_t lim_word = (lim_sel == alm_sel_low)  ? lo_fl :
                             (lim_sel == alm_sel_high) ? up_fl :
                             (lim_sel == alm_sel_hys)  ? hy_rd : `ALM_CODE_MIN;

  // Full decode; unmapped addresses read zero
  wire alm_code_t rd_word =
    lim_hit                      ? lim_word :
    (reg_addr == `ALM_OFS_CFG)   ? {10'h000, cfg_ff} :
    (reg_addr == `ALM_OFS_STA)   ? {4'h0, sta_w[0]} :
    (reg_addr == `ALM_OFS_STB)   ? {4'h0, sta_w[1]} :
    (reg_addr == `ALM_OFS_STC)   ? {4'h0, sta_w[2]} : `ALM_CODE_MIN;
  wire alm_code_t nxt_rdata = reg_rd ? rd_word : reg_rdata;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Read data holds until the next read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= `ALM_CODE_MIN;
      alert_pin  <= 1'b0;
      alert_flag <= 1'b0;
    end else begin
      reg_rdata  <= nxt_rdata;
      alert_pin  <= nxt_pin;
      alert_flag <= nxt_flag;
    end
  end
endmodule : adc_limit_monitor

// *** tb/alm_adc_model.sv ***
// Behavioural converter result stream feeding the monitor
`timescale 1ns/100ps
module alm_adc_model (
  input  wire logic         clock,     // System clock
  output logic              res_valid, // Result strobe
  output logic [3:0]        res_chan,  // Result channel
  output alm_pkg::alm_code_t res_code  // Result code
);
  import alm_pkg::*;
  initial begin
    res_valid = 1'b0;
    res_chan  = 4'h0;
    res_code  = 12'h000;
  end
  // One conversion: a one-cycle strobe, then the bus shows a scrambled code
  task automatic conv(input logic [3:0] ch, input alm_code_t code);
    @(negedge clock);
    res_valid = 1'b1;
    res_chan  = ch;
    res_code  = code;
    @(negedge clock);
    res_valid = 1'b0;
    res_chan  = ~ch;
    res_code  = ~code;
  endtask : conv
endmodule : alm_adc_model

// *** tb/alm_properties.sv ***
// Port checker of the limit monitor, with a shadow of channel zero
`timescale 1ns/100ps
module alm_properties (
  input wire logic               clock,          // Clock
  input wire logic               rst_b,          // Reset
  input wire logic               res_valid,      // Result strobe
  input wire logic [3:0]         res_chan,       // Result channel
  input wire alm_pkg::alm_code_t res_code,       // Result code
  input wire logic [1:0]         ovr_pin,        // Overrange
  input wire logic [1:0]         diode_open_pin, // Diode open
  input wire logic               reg_wr,         // Write
  input wire logic               reg_rd,         // Read
  input wire logic [7:0]         reg_addr,       // Address
  input wire alm_pkg::alm_code_t reg_wdata,      // Write data
  input wire alm_pkg::alm_code_t reg_rdata,      // Read data
  input wire logic               alert_pin,      // Event pin
  input wire logic               alert_flag      // Flag
);
  import alm_pkg::*;
  logic [1:0] cfg_ff;
  alm_code_t  u_ff;
  alm_code_t  l_ff;
  alm_code_t  h_ff;
  logic [1:0] st_ff;
  logic [2:0] act_ff;
  // Channel zero decode; sums are 13 bits wide so nothing wraps
  wire mm  = h_ff == 12'hfff;
  wire r0  = res_valid && res_chan == 4'h0;
  wire up  = r0 && res_code > u_ff;
  wire dn  = r0 && res_code < l_ff;
  wire rhi = r0 && !mm && {1'b0, res_code} + {1'b0, h_ff} <= {1'b0, u_ff};
  wire rlo = r0 && !mm && {1'b0, res_code} >= {1'b0, l_ff} + {1'b0, h_ff};
  wire wst = reg_wr && reg_addr == 8'h04;
  wire [1:0] clr    = {2{wst}} & reg_wdata[1:0];
  wire [1:0] nxt_st = {up && !mm, dn && !mm} | (st_ff & ~{rhi, rlo} & ~clr);
  // Shadow of configuration, channel zero registers and status bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= 2'h3;
      u_ff   <= 12'hfff;
      l_ff   <= 12'h000;
      h_ff   <= 12'h008;
      st_ff  <= 2'h0;
      act_ff <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h03) cfg_ff <= reg_wdata[1:0];
      u_ff   <= (reg_wr && reg_addr == 8'h41) ? reg_wdata : (mm && up) ? res_code : u_ff;
      l_ff   <= (reg_wr && reg_addr == 8'h40) ? reg_wdata : (mm && dn) ? res_code : l_ff;
      if (reg_wr && reg_addr == 8'h42) h_ff <= reg_wdata;
      st_ff  <= nxt_st;
      act_ff <= {act_ff[1:0], reg_wr | res_valid};
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_hi;
    r0 ##0 (!mm && res_code > u_ff);
  endsequence
  sequence s_lo;
    r0 ##0 (!mm && res_code < l_ff);
  endsequence
  cfg_read_a: assert property (reg_rd && reg_addr == 8'h03
    |=> reg_rdata == {10'h0, $past(cfg_ff)})
    else $error("config readback wrong");
  upper_read_a: assert property (reg_rd && reg_addr == 8'h41
    |=> reg_rdata == $past(u_ff))
    else $error("upper limit readback wrong");
  status_read_a: assert property (reg_rd && wst == 1'b0 && reg_addr == 8'h04
    |=> reg_rdata[1:0] == $past(st_ff))
    else $error("status bits wrong");
  high_flag_a: assert property (s_hi ##0 cfg_ff[1] |-> ##2 alert_flag)
    else $error("flag missing after high result");
  low_pin_a: assert property (s_lo ##0 cfg_ff[0] |-> ##2 alert_pin)
    else $error("pin missing after low result");
  ovr_sticky_a: assert property ((ovr_pin != 2'h0) [*4] ##0 cfg_ff[0] |-> ##[0:2] alert_pin)
    else $error("overrange did not raise pin");
  pin_drop_a: assert property ($fell(alert_pin) |-> act_ff != 3'h0)
    else $error("pin fell without cause");
  flag_gate_a: assert property (!cfg_ff[1] [*2] |-> !alert_flag)
    else $error("flag shown while disabled");
endmodule : alm_properties

// *** tb/adc_limit_monitor_tb.sv ***
// Self-checking bench of the ADC limit monitor
`timescale 1ns/100ps
module adc_limit_monitor_tb;
  import alm_pkg::*;
  logic       clock, rst_b, reg_wr, reg_rd, res_valid, alert_pin, alert_flag;
  logic [3:0] res_chan;
  logic [1:0] ovr_pin, diode_open_pin;
  logic [7:0] reg_addr;
  alm_code_t  res_code, reg_wdata, reg_rdata;
  int         errors, compares;
  adc_limit_monitor uut (.*);
  alm_adc_model adc (.clock(clock), .res_valid(res_valid), .res_chan(res_chan),
                     .res_code(res_code));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input alm_code_t got, input alm_code_t exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input alm_code_t d);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input alm_code_t e);
    @(negedge clock);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd   = 1'b0;
    chk(reg_rdata, e);
  endtask : rd
  // Converts, then waits until the alert outputs have followed
  task automatic cv(input logic [3:0] c, input alm_code_t d);
    adc.conv(c, d);
    repeat (2) @(negedge clock);
  endtask : cv
  task automatic po(input logic [1:0] e);
    chk({10'h0, alert_pin, alert_flag}, {10'h0, e});
  endtask : po
  task automatic t_reset;
    po(2'b00);
    rd(8'h41, 12'hfff);
    rd(8'h40, 12'h000);
    rd(8'h42, 12'h008);
    rd(8'h62, 12'h020);
    rd(8'h06, 12'h000);
    rd(8'h03, 12'h003);
  endtask : t_reset
  // Raise on the upper limit, hold inside the band, release past it
  task automatic t_hys;
    alm_code_t h[2] = '{12'h008, 12'h010};
    wr(8'h41, 12'h800);
    foreach (h[i]) begin
      wr(8'h42, h[i]);
      cv(4'h0, 12'h800);
      po(2'b00);
      cv(4'h0, 12'h801);
      po(2'b11);
      cv(4'h0, 12'h801 - h[i]);
      rd(8'h04, 12'h002);
      cv(4'h0, 12'h800 - h[i]);
      rd(8'h04, 12'h000);
      po(2'b00);
    end
    rd(8'h46, 12'h008);
    wr(8'h41, 12'h700);
    wr(8'h42, 12'h77d);
    cv(4'h0, 12'h701);
    cv(4'h0, 12'h000);
    rd(8'h04, 12'h002);
    wr(8'h04, 12'h0ff);
    wr(8'h41, 12'hfff);
    wr(8'h42, 12'h008);
  endtask : t_hys
  // Lower limit, a second channel joining, partial and full clears
  task automatic t_low;
    wr(8'h40, 12'h100);
    wr(8'h45, 12'h010);
    cv(4'h0, 12'h0ff);
    cv(4'h1, 12'h011);
    rd(8'h04, 12'h009);
    wr(8'h04, 12'h001);
    rd(8'h04, 12'h008);
    wr(8'h04, 12'h0ff);
    rd(8'h04, 12'h000);
    chk({11'h0, alert_pin}, 12'h000);
    wr(8'h40, 12'h000);
    wr(8'h45, 12'hfff);
  endtask : t_low
  task automatic t_mm;
    wr(8'h42, 12'hfff);
    wr(8'h41, 12'h400);
    wr(8'h40, 12'h300);
    cv(4'h0, 12'h900);
    cv(4'h0, 12'h200);
    cv(4'h0, 12'h350);
    rd(8'h41, 12'h900);
    rd(8'h40, 12'h200);
    rd(8'h04, 12'h000);
    wr(8'h42, 12'h008);
    wr(8'h41, 12'hfff);
    wr(8'h40, 12'h000);
  endtask : t_mm
  // Overrange latches until written off; an open diode shows in limit bit 11
  task automatic t_pins;
    ovr_pin        = 2'b10;
    diode_open_pin = 2'b01;
    repeat (6) @(negedge clock);
    rd(8'h59, 12'h7ff);
    rd(8'h06, 12'h080);
    ovr_pin        = 2'b00;
    diode_open_pin = 2'b00;
    repeat (6) @(negedge clock);
    rd(8'h05, 12'h020);
    wr(8'h06, 12'h080);
    @(negedge clock);
    chk({11'h0, alert_pin}, 12'h001);
    wr(8'h05, 12'h030);
    @(negedge clock);
    chk({11'h0, alert_pin}, 12'h000);
    rd(8'h59, 12'hfff);
  endtask : t_pins
  task automatic t_cfg;
    wr(8'h03, 12'h002);
    wr(8'h41, 12'h800);
    cv(4'h0, 12'h801);
    po(2'b01);
    wr(8'h03, 12'h001);
    @(negedge clock);
    po(2'b10);
    rd(8'h03, 12'h001);
    wr(8'h04, 12'h0ff);
    wr(8'h41, 12'hfff);
    wr(8'h03, 12'h003);
  endtask : t_cfg
  initial begin
    errors         = 0;
    compares       = 0;
    rst_b          = 1'b0;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 12'h000;
    ovr_pin        = 2'b00;
    diode_open_pin = 2'b00;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    t_reset;
    t_hys;
    t_low;
    t_mm;
    t_pins;
    t_cfg;
    report_and_stop;
  end
  // Watchdog well beyond the roughly 200 cycles the tests take
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    report_and_stop;
  end
  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
endmodule : adc_limit_monitor_tb
bind adc_limit_monitor alm_properties chk_i (.*);
